// ---- timer_sync_defs.svh ----
// Offsets, bit positions, reset values and timing counts of the timer sync.
`ifndef TIMER_SYNC_DEFS_SVH
`define TIMER_SYNC_DEFS_SVH

// Byte offsets of the registers on the bus.
`define OFF_COUNT 8'h00
`define OFF_COMPARE 8'h04
`define OFF_CONTROL 8'h08
`define OFF_ASYNC_STATUS 8'h0C
`define OFF_IRQ_MASK 8'h10
`define OFF_IRQ_FLAGS 8'h14

// Bit positions in the async status register.
`define BIT_ASYNC_SEL 3
`define BIT_COUNT_BUSY 2
`define BIT_COMPARE_BUSY 1
`define BIT_CTRL_BUSY 0

// Bit positions in the mask and flag registers.
`define BIT_COMPARE 7
`define BIT_OVERFLOW 6

// Control register fields.
`define BIT_WGM_HI 3
`define BIT_WGM_LO 6
`define CTRL_COM_MSB 5
`define CTRL_COM_LSB 4
`define CTRL_CS_MSB 2
`define CTRL_CS_LSB 0

// Waveform mode codes, formed as {bit 3, bit 6}.
`define WGM_PHASE_PWM 2'h1
`define WGM_CTC 2'h2

// Reset values.
`define RST_BYTE 8'h00
`define RST_MASK 8'h00
`define RST_FLAGS 8'h00

// Timing counts.
`define STAGE_EDGES 2'h2
`define FLAG_SYNC_CYCLES 3
`define COUNT_MAX 8'hFF

`endif

// ---- timer_sync_pkg.sv ----
// Types shared by the timer synchronisation modules.
package timer_sync_pkg;

   // Progress of one staging register towards its destination.
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT1 = 2'b01,
      ST_WAIT2 = 2'b10
   } stage_state_e;

   // One byte of register data.
   typedef logic [7:0] byte_t;

endpackage

// ---- stage_if.sv ----
// Carrier between the register front end and one staging channel.
`timescale 1ns/1ps
interface stage_if;
   logic wr;                          // One-cycle write strobe.
   timer_sync_pkg::byte_t wdata;      // Byte written by software.
   timer_sync_pkg::byte_t stage_val;  // Current staging contents.
   logic busy;                        // Update still in flight.
   logic commit;                      // Pulse: load stage_val now.
   modport owner(output wr, output wdata,
                 input stage_val, input busy, input commit);
   modport chan(input wr, input wdata,
                output stage_val, output busy, output commit);
endinterface

// ---- stage_channel.sv ----
// One staging register with its update-busy tracking.
`timescale 1ns/1ps
`include "timer_sync_defs.svh"
module stage_channel (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Timer clock rising edge and mode.
   input wire logic xtal_tick,
   input wire logic async_mode,
   // Link to the register front end.
   stage_if.chan bus
);

   timer_sync_pkg::byte_t stage_q;       // Staged byte.
   timer_sync_pkg::byte_t stage_d;
   timer_sync_pkg::stage_state_e st_q;   // Transfer progress.
   timer_sync_pkg::stage_state_e st_d;
   logic commit_q;                       // Registered load pulse.
   logic commit_d;
   logic [1:0] edge_cnt_q;               // Edges since write, checks only.
   logic [1:0] edge_cnt_d;

   // Next state of the staging channel.
   always_comb begin
      stage_d = stage_q;
      st_d = st_q;
      commit_d = 1'b0;
      if (bus.wr) begin
         stage_d = bus.wdata;
         if (async_mode) begin
            st_d = timer_sync_pkg::ST_WAIT1;
         end else begin
            // Synchronous timer takes the byte at once.
            st_d = timer_sync_pkg::ST_IDLE;
            commit_d = 1'b1;
         end
      end else begin
         case (st_q)
            timer_sync_pkg::ST_IDLE: begin
               st_d = timer_sync_pkg::ST_IDLE;
            end
            timer_sync_pkg::ST_WAIT1: begin
               if (xtal_tick) begin
                  st_d = timer_sync_pkg::ST_WAIT2;
               end
            end
            timer_sync_pkg::ST_WAIT2: begin
               if (xtal_tick) begin
                  st_d = timer_sync_pkg::ST_IDLE;
                  commit_d = 1'b1;
               end
            end
            default: begin
               st_d = timer_sync_pkg::ST_IDLE;
            end
         endcase
      end
      // Helper count of timer edges, saturating at three.
      edge_cnt_d = edge_cnt_q;
      if (bus.wr) begin
         edge_cnt_d = 2'h0;
      end else if (xtal_tick && edge_cnt_q != 2'h3) begin
         edge_cnt_d = edge_cnt_q + 2'h1;
      end
   end

   // Register the channel state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage_q <= `RST_BYTE;
         st_q <= timer_sync_pkg::ST_IDLE;
         commit_q <= 1'b0;
         edge_cnt_q <= 2'h0;
      end else begin
         stage_q <= stage_d;
         st_q <= st_d;
         commit_q <= commit_d;
         edge_cnt_q <= edge_cnt_d;
      end
   end

   // busy visible straight after write
   // In async mode busy covers the load pulse so it never drops before the destination.
   assign bus.busy = (st_q != timer_sync_pkg::ST_IDLE) ||
                     (commit_q && async_mode);
   assign bus.commit = commit_q;
   assign bus.stage_val = stage_q;

   a_busy_on_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      bus.wr && async_mode |=> bus.busy)
      else $error("busy not set after async write");

   a_two_edges: assert property (
      @(posedge hclk) disable iff (!hresetn)
      bus.commit && async_mode |-> edge_cnt_q == `STAGE_EDGES)
      else $error("commit not after two timer edges");

   a_busy_holds: assert property (
      @(posedge hclk) disable iff (!hresetn)
      bus.busy && !bus.commit && async_mode && !bus.wr |=> bus.busy)
      else $error("busy dropped before commit");

   a_sync_direct: assert property (
      @(posedge hclk) disable iff (!hresetn)
      bus.wr && !async_mode |=> bus.commit ##1 !bus.busy)
      else $error("sync write not applied at once");

endmodule

// ---- async_timer_sync_and_irq.sv ----
// Clock crossing, staging and interrupt flags of the 8-bit async timer.
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "timer_sync_defs.svh"
// Notes on behaviour
// - Control write sets busy; cleared after transfer.
// - Count reads copy when async; compare, control read staging.
// - Writes staged, applied after two timer edges.
// - Three independent staging registers.
// - No compare match during count/compare transfer.
// - Wake logic needs one timer cycle rearm.
// - Oscillator on only with crystal selected; off in deep sleep.
// - Wake starts on following timer cycle.
// - Count copy refreshed each timer rising edge.
// - Flag sync takes three cycles plus tick.
// - Compare pin changes on timer clock.
// - Compare flag, mask bit 7, enable: interrupt.
// - Overflow flag, mask bit 6, enable: interrupt.
// - Compare flag set on match, W1C/vector clear.
// - Overflow flag set on overflow, W1C/vector clear.
// - PWM overflow flag set at bottom reversal.
// - Count and compare writes set their busy.
// - Select bit picks I/O or crystal clock.
module async_timer_sync_and_irq (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Crystal clock pin, asynchronous to hclk.
   input wire logic xtal_clock_input,
   // CPU side signals on hclk.
   input wire logic global_irq_enable,
   input wire logic cmp_vector_ack,
   input wire logic ovf_vector_ack,
   input wire logic sleep_active,
   input wire logic sleep_deep,
   // Timer outputs.
   output logic oc_pin,
   output logic cmp_irq,
   output logic ovf_irq,
   output logic osc_enable,
   output logic wake_req
);

   // Byte address compare used by the read and the write decode.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   stage_if cnt_ch();   // Counter staging channel.
   stage_if cmp_ch();   // Compare staging channel.
   stage_if ctl_ch();   // Control staging channel.

   // Bus state.
   logic dp_wr_q;           // Data phase of a write is open.
   logic dp_wr_d;
   logic [7:0] dp_addr_q;   // Byte address of that write.
   logic [7:0] dp_addr_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic hreadyout_q;
   logic ap_valid;          // Address phase accepted this cycle.
   logic [7:0] wbyte;       // Written byte in the data phase.

   // Timer state.
   logic [2:0] xs_q;        // Crystal pin synchroniser and edge stage.
   logic [2:0] xs_d;
   logic xtal_rise;         // One-cycle pulse per crystal rising edge.
   logic async_q;           // Clock source select.
   logic async_d;
   timer_sync_pkg::byte_t count_q;
   timer_sync_pkg::byte_t count_d;
   timer_sync_pkg::byte_t compare_q;
   timer_sync_pkg::byte_t compare_d;
   timer_sync_pkg::byte_t ctrl_q;
   timer_sync_pkg::byte_t ctrl_d;
   timer_sync_pkg::byte_t copy_q;   // Count copy for CPU reads.
   timer_sync_pkg::byte_t copy_d;
   logic dir_q;             // Phase correct PWM counting down.
   logic dir_d;
   logic oc_q;
   logic oc_d;
   logic tmr_tick;          // Timer clock event in hclk terms.
   logic [1:0] wgm;
   timer_sync_pkg::byte_t top;
   logic match_ev;
   logic ovf_ev;

   // Flag and wake state.
   logic [1:0] pipe0_q;     // Flag events, first resync stage.
   logic [1:0] pipe0_d;
   logic [1:0] pipe1_q;     // Flag events, second resync stage.
   logic [1:0] pipe1_d;
   timer_sync_pkg::byte_t mask_q;
   timer_sync_pkg::byte_t mask_d;
   logic [1:0] flags_q;     // {compare, overflow}.
   logic [1:0] flags_d;
   logic [1:0] flag_set;
   logic [1:0] flag_clr;
   logic cmp_irq_q;
   logic cmp_irq_d;
   logic ovf_irq_q;
   logic ovf_irq_d;
   logic osc_q;
   logic osc_d;
   logic armed_q;           // Wake logic has seen a timer edge.
   logic armed_d;
   logic pend_q;            // Wake condition met while asleep.
   logic pend_d;
   logic wake_q;
   logic wake_d;
   logic sleep_prev_q;
   logic sleep_prev_d;

   stage_channel u_cnt (.hclk(hclk), .hresetn(hresetn),
      .xtal_tick(xtal_rise), .async_mode(async_q), .bus(cnt_ch));
   stage_channel u_cmp (.hclk(hclk), .hresetn(hresetn),
      .xtal_tick(xtal_rise), .async_mode(async_q), .bus(cmp_ch));
   stage_channel u_ctl (.hclk(hclk), .hresetn(hresetn),
      .xtal_tick(xtal_rise), .async_mode(async_q), .bus(ctl_ch));

   // Write strobes land in the data phase, so zero wait states suffice.
   assign ap_valid = hsel && htrans[1] && hready;
   assign wbyte = hwdata[7:0];
   assign cnt_ch.wr = dp_wr_q && hit(dp_addr_q, `OFF_COUNT);
   assign cmp_ch.wr = dp_wr_q && hit(dp_addr_q, `OFF_COMPARE);
   assign ctl_ch.wr = dp_wr_q && hit(dp_addr_q, `OFF_CONTROL);
   assign cnt_ch.wdata = wbyte;
   assign cmp_ch.wdata = wbyte;
   assign ctl_ch.wdata = wbyte;

   // Bus front end: capture address phase, prepare read data.
   always_comb begin
      dp_wr_d = ap_valid && hwrite;
      dp_addr_d = haddr[7:0];
      hrdata_d = 32'h0000_0000;
      async_d = async_q;
      mask_d = mask_q;
      if (ap_valid && !hwrite) begin
         if (hit(haddr[7:0], `OFF_COUNT)) begin
            hrdata_d[7:0] = async_q ? copy_q : count_q;
         end else if (hit(haddr[7:0], `OFF_COMPARE)) begin
            hrdata_d[7:0] = cmp_ch.stage_val;
         end else if (hit(haddr[7:0], `OFF_CONTROL)) begin
            hrdata_d[7:0] = ctl_ch.stage_val;
         end else if (hit(haddr[7:0], `OFF_ASYNC_STATUS)) begin
            hrdata_d[`BIT_ASYNC_SEL] = async_q;
            hrdata_d[`BIT_COUNT_BUSY] = cnt_ch.busy;
            hrdata_d[`BIT_COMPARE_BUSY] = cmp_ch.busy;
            hrdata_d[`BIT_CTRL_BUSY] = ctl_ch.busy;
         end else if (hit(haddr[7:0], `OFF_IRQ_MASK)) begin
            hrdata_d[7:0] = mask_q;
         end else if (hit(haddr[7:0], `OFF_IRQ_FLAGS)) begin
            hrdata_d[`BIT_COMPARE] = flags_q[1];
            hrdata_d[`BIT_OVERFLOW] = flags_q[0];
         end
      end
      if (dp_wr_q && hit(dp_addr_q, `OFF_ASYNC_STATUS)) begin
         async_d = wbyte[`BIT_ASYNC_SEL];
      end
      if (dp_wr_q && hit(dp_addr_q, `OFF_IRQ_MASK)) begin
         mask_d = wbyte;
      end
   end

   // Register the bus front end.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_q <= 1'b0;
         dp_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b0;
         async_q <= 1'b0;
         mask_q <= `RST_MASK;
      end else begin
         dp_wr_q <= dp_wr_d;
         dp_addr_q <= dp_addr_d;
         hrdata_q <= hrdata_d;
         hreadyout_q <= 1'b1;
         async_q <= async_d;
         mask_q <= mask_d;
      end
   end

   // Timer core next state; counting modes are kept minimal here.
   always_comb begin
      xs_d = {xs_q[1:0], xtal_clock_input};
      wgm = {ctrl_q[`BIT_WGM_HI], ctrl_q[`BIT_WGM_LO]};
      top = (wgm == `WGM_CTC) ? compare_q : `COUNT_MAX;
      tmr_tick = (ctrl_q[`CTRL_CS_MSB:`CTRL_CS_LSB] != 3'h0) &&
                 (async_q ? xtal_rise : 1'b1);
      match_ev = tmr_tick && (count_q == compare_q) &&
                 !cnt_ch.busy && !cmp_ch.busy;
      ovf_ev = 1'b0;
      count_d = count_q;
      dir_d = dir_q;
      compare_d = cmp_ch.commit ? cmp_ch.stage_val : compare_q;
      ctrl_d = ctl_ch.commit ? ctl_ch.stage_val : ctrl_q;
      copy_d = xtal_rise ? count_q : copy_q;
      if (cnt_ch.commit) begin
         count_d = cnt_ch.stage_val;
      end else if (tmr_tick && wgm == `WGM_PHASE_PWM) begin
         if (dir_q && count_q == 8'h00) begin
            dir_d = 1'b0;
            ovf_ev = 1'b1;
            count_d = 8'h01;
         end else if (dir_q) begin
            count_d = count_q - 8'h01;
         end else if (count_q == `COUNT_MAX) begin
            dir_d = 1'b1;
            count_d = count_q - 8'h01;
         end else begin
            count_d = count_q + 8'h01;
         end
      end else if (tmr_tick) begin
         ovf_ev = (count_q == `COUNT_MAX);
         count_d = (count_q == top) ? 8'h00 : count_q + 8'h01;
      end
      oc_d = oc_q;
      if (match_ev) begin
         case (ctrl_q[`CTRL_COM_MSB:`CTRL_COM_LSB])
            2'h1: oc_d = !oc_q;
            2'h2: oc_d = 1'b0;
            2'h3: oc_d = 1'b1;
            default: oc_d = oc_q;
         endcase
      end
   end

   // Register the timer core; xs_q[0] feeds only xs_q[1].
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xs_q <= 3'h0;
         count_q <= `RST_BYTE;
         compare_q <= `RST_BYTE;
         ctrl_q <= `RST_BYTE;
         copy_q <= `RST_BYTE;
         dir_q <= 1'b0;
         oc_q <= 1'b0;
      end else begin
         xs_q <= xs_d;
         count_q <= count_d;
         compare_q <= compare_d;
         ctrl_q <= ctrl_d;
         copy_q <= copy_d;
         dir_q <= dir_d;
         oc_q <= oc_d;
      end
   end
   assign xtal_rise = xs_q[1] && !xs_q[2];

   // Flags, interrupt requests, oscillator enable and wake logic.
   always_comb begin
      pipe0_d = async_q ? {match_ev, ovf_ev} : 2'h0;
      pipe1_d = pipe0_q;
      flag_set = async_q ? pipe1_q : {match_ev, ovf_ev};
      flag_clr[1] = cmp_vector_ack ||
         (dp_wr_q && hit(dp_addr_q, `OFF_IRQ_FLAGS) && wbyte[`BIT_COMPARE]);
      flag_clr[0] = ovf_vector_ack ||
         (dp_wr_q && hit(dp_addr_q, `OFF_IRQ_FLAGS) && wbyte[`BIT_OVERFLOW]);
      // A set in the same cycle as a clear wins.
      flags_d = (flags_q & ~flag_clr) | flag_set;
      cmp_irq_d = flags_q[1] && mask_q[`BIT_COMPARE] && global_irq_enable;
      ovf_irq_d = flags_q[0] && mask_q[`BIT_OVERFLOW] && global_irq_enable;
      // oscillator runs only with the crystal selected and stops in deep sleep
      osc_d = async_q && !(sleep_active && sleep_deep);
      sleep_prev_d = sleep_active;
      armed_d = armed_q;
      if (sleep_prev_q && !sleep_active) begin
         armed_d = 1'b0;
      end else if (xtal_rise && !sleep_active) begin
         armed_d = 1'b1;
      end
      pend_d = pend_q;
      wake_d = wake_q;
      if (!sleep_active) begin
         pend_d = 1'b0;
         wake_d = 1'b0;
      end else begin
         if (armed_q && ((flags_q[1] && mask_q[`BIT_COMPARE]) ||
                         (flags_q[0] && mask_q[`BIT_OVERFLOW]))) begin
            pend_d = 1'b1;
         end
         if (pend_q && xtal_rise) begin
            wake_d = 1'b1;
         end
      end
   end

   // Register flags and wake state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pipe0_q <= 2'h0;
         pipe1_q <= 2'h0;
         flags_q <= 2'h0;
         cmp_irq_q <= 1'b0;
         ovf_irq_q <= 1'b0;
         osc_q <= 1'b0;
         armed_q <= 1'b1;
         pend_q <= 1'b0;
         wake_q <= 1'b0;
         sleep_prev_q <= 1'b0;
      end else begin
         pipe0_q <= pipe0_d;
         pipe1_q <= pipe1_d;
         flags_q <= flags_d;
         cmp_irq_q <= cmp_irq_d;
         ovf_irq_q <= ovf_irq_d;
         osc_q <= osc_d;
         armed_q <= armed_d;
         pend_q <= pend_d;
         wake_q <= wake_d;
         sleep_prev_q <= sleep_prev_d;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign oc_pin = oc_q;
   assign cmp_irq = cmp_irq_q;
   assign ovf_irq = ovf_irq_q;
   assign osc_enable = osc_q;
   assign wake_req = wake_q;

   sequence s_async_match;
      match_ev && async_q && !cmp_vector_ack;
   endsequence

   a_match_blocked: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cnt_ch.busy || cmp_ch.busy) |-> !match_ev)
      else $error("compare match during transfer");

   a_flag_sync: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_async_match |-> ##`FLAG_SYNC_CYCLES flags_q[1])
      else $error("compare flag not set after resync");

   a_cmp_irq_req: assert property (
      @(posedge hclk) disable iff (!hresetn)
      flags_q[1] && mask_q[`BIT_COMPARE] && global_irq_enable |=> cmp_irq)
      else $error("compare interrupt not requested");

   a_ovf_irq_req: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !flags_q[0] |=> !ovf_irq)
      else $error("overflow interrupt without flag");

   a_flag_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      flag_clr[1] && !flag_set[1] |=> !flags_q[1])
      else $error("compare flag not cleared");

   a_osc_deep: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sleep_active && sleep_deep |=> !osc_enable)
      else $error("oscillator running in deep sleep");

   a_copy_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !xtal_rise |=> $stable(copy_q))
      else $error("count copy changed without timer edge");

   a_wake_edge: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(wake_req) |-> $past(xtal_rise) && $past(pend_q))
      else $error("wake not on timer edge");

endmodule

// ---- xtal_model.sv ----
// Behavioural crystal oscillator that feeds the timer's clock pin.
`timescale 1ns/1ps
module xtal_model (
   // Oscillator run request from the block.
   input wire logic enable,
   // Clock pin towards the block.
   output logic xclk
);
   // Period 125 ns, far slower than the 10 ns bus clock.
   // ratio above four
   // stopped pin holds
   // The pin holds its level while stopped, as a halted oscillator would.
   initial begin
      // The pin starts low.
      xclk = 1'b0;
      // A small offset keeps the pin's edges clear of the bus clock's edges.
      #1;
      forever begin
         #62.5;
         if (enable) begin
            xclk = ~xclk;
         end
      end
   end
endmodule

// ---- test_async_timer_sync_and_irq.sv ----
// Self-checking bench for the async timer crossing and interrupt flags.
`timescale 1ns/1ps
`include "timer_sync_defs.svh"
module test_async_timer_sync_and_irq;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic global_irq_enable = 1'b0;
   logic cmp_vector_ack = 1'b0;
   logic ovf_vector_ack = 1'b0;
   logic sleep_active = 1'b0;
   logic sleep_deep = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, xclk, oc_pin, cmp_irq, ovf_irq;
   logic osc_enable, wake_req;
   int mismatches = 0;
   int tests_run = 0;
   logic [31:0] rd;
   logic [7:0] rv;
   logic ov;

   // Bus clock, 100 MHz.
   always #5 hclk = ~hclk;

   xtal_model xtal (.enable(osc_enable), .xclk(xclk));

   async_timer_sync_and_irq uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .xtal_clock_input(xclk),
      .global_irq_enable(global_irq_enable),
      .cmp_vector_ack(cmp_vector_ack), .ovf_vector_ack(ovf_vector_ack),
      .sleep_active(sleep_active), .sleep_deep(sleep_deep),
      .oc_pin(oc_pin), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
      .osc_enable(osc_enable), .wake_req(wake_req));

   // Expected async status word from its four bits.
   function automatic logic [31:0] stat(input logic s, c, p, t);
      return {28'h0, s, c, p, t};
   endfunction

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One single AHB transfer; the master waits on hready, never a count.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      hsel <= 1'b0;
   endtask

   // Polls a register until the masked bits match; bounded by a count.
   task automatic poll(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] v);
      int n;
      n = 0;
      do begin
         xfer(1'b0, a, 32'h0);
         n++;
      end while ((rd & m) !== v && n < 3000);
   endtask

   // Closing verdict, reached from the main sequence or the watchdog.
   task automatic end_of_test;
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Watchdog: the whole run should end well inside this span.
   initial begin
      #500000;
      mismatches++;
      end_of_test();
   end

   initial begin
      rv = 8'($urandom(32'h786FE3E3));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and an unmapped offset that reads zero.
      xfer(1'b0, `OFF_IRQ_MASK, 32'h0); chk(rd, 32'h0);
      xfer(1'b0, `OFF_IRQ_FLAGS, 32'h0); chk(rd, 32'h0);
      xfer(1'b0, `OFF_ASYNC_STATUS, 32'h0); chk(rd, stat(0, 0, 0, 0));
      xfer(1'b0, 8'h18, 32'h0); chk(rd, 32'h0);
      // Mask holds a random byte.
      rv = 8'($urandom);
      xfer(1'b1, `OFF_IRQ_MASK, {24'h0, rv});
      xfer(1'b0, `OFF_IRQ_MASK, 32'h0); chk(rd, {24'h0, rv});
      xfer(1'b1, `OFF_IRQ_MASK, 32'h0);
      // Timer clocked from the bus clock: the count takes a write at once.
      xfer(1'b1, `OFF_COUNT, 32'h5A);
      xfer(1'b0, `OFF_COUNT, 32'h0); chk(rd, 32'h5A);
      // Switch to the crystal clock with interrupts masked.
      xfer(1'b1, `OFF_ASYNC_STATUS, 32'h8);
      xfer(1'b0, `OFF_ASYNC_STATUS, 32'h0); chk(rd, stat(1, 0, 0, 0));
      // Two channels in flight at once, seen busy straight away.
      rv = 8'($urandom);
      xfer(1'b1, `OFF_COMPARE, {24'h0, rv});
      xfer(1'b1, `OFF_CONTROL, 32'h0);
      xfer(1'b0, `OFF_ASYNC_STATUS, 32'h0); chk(rd, stat(1, 0, 1, 1));
      xfer(1'b0, `OFF_COMPARE, 32'h0); chk(rd, {24'h0, rv});
      poll(`OFF_ASYNC_STATUS, 32'h7, 32'h0);
      chk(rd, stat(1, 0, 0, 0));
      // Count near the top, then run: overflow after a few ticks.
      xfer(1'b1, `OFF_COUNT, 32'hFD);
      xfer(1'b0, `OFF_ASYNC_STATUS, 32'h0); chk(rd, stat(1, 1, 0, 0));
      poll(`OFF_ASYNC_STATUS, 32'h7, 32'h0);
      xfer(1'b1, `OFF_COMPARE, {24'h0, rv});
      poll(`OFF_ASYNC_STATUS, 32'h7, 32'h0);
      xfer(1'b0, `OFF_COUNT, 32'h0); chk(rd, 32'hFD);
      // Start counting with the pin toggling on every match.
      xfer(1'b1, `OFF_CONTROL, 32'h11);
      xfer(1'b0, `OFF_ASYNC_STATUS, 32'h0); chk(rd, stat(1, 0, 0, 1));
      xfer(1'b0, `OFF_CONTROL, 32'h0); chk(rd, 32'h11);
      poll(`OFF_ASYNC_STATUS, 32'h7, 32'h0);
      poll(`OFF_IRQ_FLAGS, 32'h40, 32'h40); chk(rd & 32'h40, 32'h40);
      // Overflow request needs mask bit 6 and the global enable.
      xfer(1'b1, `OFF_IRQ_MASK, 32'h40);
      repeat (3) @(posedge hclk);
      chk(ovf_irq, 1'b0);
      global_irq_enable <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(ovf_irq, 1'b1);
      xfer(1'b1, `OFF_IRQ_FLAGS, 32'h40);
      xfer(1'b0, `OFF_IRQ_FLAGS, 32'h0); chk(rd & 32'h40, 32'h0);
      chk(ovf_irq, 1'b0);
      // Vector execution clears the overflow flag as well.
      poll(`OFF_IRQ_FLAGS, 32'h40, 32'h40);
      ovf_vector_ack <= 1'b1;
      @(posedge hclk);
      ovf_vector_ack <= 1'b0;
      xfer(1'b0, `OFF_IRQ_FLAGS, 32'h0); chk(rd & 32'h40, 32'h0);
      // Compare at a random value while the count runs.
      rv = 8'($urandom);
      xfer(1'b1, `OFF_COMPARE, {24'h0, rv});
      poll(`OFF_ASYNC_STATUS, 32'h7, 32'h0);
      xfer(1'b1, `OFF_IRQ_FLAGS, 32'h80);
      ov = oc_pin;
      poll(`OFF_IRQ_FLAGS, 32'h80, 32'h80); chk(rd & 32'h80, 32'h80);
      chk(oc_pin, !ov);
      xfer(1'b1, `OFF_IRQ_MASK, 32'h80);
      repeat (3) @(posedge hclk);
      chk(cmp_irq, 1'b1);
      // Vector execution clears the compare flag.
      @(posedge hclk);
      cmp_vector_ack <= 1'b1;
      @(posedge hclk);
      cmp_vector_ack <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(cmp_irq, 1'b0);
      xfer(1'b0, `OFF_IRQ_FLAGS, 32'h0); chk(rd & 32'h80, 32'h0);
      xfer(1'b1, `OFF_CONTROL, 32'h11);
      poll(`OFF_ASYNC_STATUS, 32'h7, 32'h0);
      // Deep sleep stops the oscillator; light sleep keeps it.
      sleep_active <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(osc_enable, 1'b1);
      // The next compare match wakes the block from light sleep.
      repeat (4000) if (wake_req !== 1'b1) @(posedge hclk);
      chk(wake_req, 1'b1);
      sleep_deep <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(osc_enable, 1'b0);
      sleep_active <= 1'b0;
      sleep_deep <= 1'b0;
      ovf_vector_ack <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(wake_req, 1'b0);
      end_of_test();
   end
endmodule
